// [rtl/adc_seq_pkg.sv]
// Shared constants, carriers and state types of the converter sequencer
package adc_seq_pkg;

   // Register byte offsets
   localparam logic [31:0] OFS_CTRL0   = 32'h0000_0000;
   localparam logic [31:0] OFS_CTRL1   = 32'h0000_0004;
   localparam logic [31:0] OFS_CTRL2   = 32'h0000_0008;
   localparam logic [31:0] OFS_RES_HI  = 32'h0000_000C;
   localparam logic [31:0] OFS_RES_LO  = 32'h0000_0010;
   localparam logic [31:0] OFS_STATUS  = 32'h0000_0014;
   localparam logic [31:0] OFS_MASK    = 32'h0000_0018;

   // Field positions
   localparam int unsigned START_BIT   = 0;
   localparam int unsigned PWR_BIT     = 1;
   localparam int unsigned BUSY_BIT    = 2;
   localparam int unsigned FMT_BIT     = 3;
   localparam int unsigned CH_LSB      = 4;
   localparam int unsigned SRC_LSB     = 0;
   localparam int unsigned DIV_LSB     = 4;
   localparam int unsigned REF_LSB     = 0;
   localparam int unsigned DONE_BIT    = 0;

   // Sequence lengths in converter clocks, result layout
   localparam logic [3:0]  SAMPLE_CLKS = 4'h4;
   localparam logic [3:0]  CONV_CLKS   = 4'hC;
   localparam logic [3:0]  RES_TOP     = 4'hB;
   localparam logic [11:0] SAR_FIRST   = 12'h800;
   localparam logic [11:0] FULL_SCALE  = 12'hFFF;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_type;

   // Controls toward the input multiplexer and conversion core
   typedef struct packed {
      logic        power_en;
      logic        sample_en;
      logic        ext_connect;
      logic [3:0]  ext_sel;
      logic [3:0]  src_sel;
      logic [1:0]  ref_sel;
      logic [11:0] sar_code;
   } analog_ctl_type;

   typedef struct packed {
      conv_state_type st;
      logic [3:0]     cnt;
      logic [11:0]    sar;
      logic [11:0]    result;
      logic           start;
      logic           pwr;
      logic           fmt;
      logic [3:0]     ch;
      logic [3:0]     src;
      logic [2:0]     div;
      logic [1:0]     rsel;
      logic           stat;
      logic           mask;
      logic [2:0]     cmp_s;
      logic           cmp;
      logic           awrdy;
      logic           wrdy;
      logic           have_aw;
      logic           have_w;
      logic [31:0]    awaddr;
      logic [31:0]    wdata;
      logic [3:0]     wstrb;
      logic           bvalid;
      logic [1:0]     bresp;
      logic           arrdy;
      logic           rvalid;
      logic [31:0]    rdata;
      logic [1:0]     rresp;
      analog_ctl_type ana;
      logic           busy;
      logic           irq;
   } seq_state_type;

   // Every field idles at zero: powered down, external channel 0, divide by 1
   localparam seq_state_type SEQ_RESET = '0;

   localparam logic [6:0] DIV_CNT_RESET = 7'h00;

   function automatic logic src_is_external(logic [3:0] s);
      return (s == 4'h0) || (s == 4'h4) || (s[3:2] == 2'b11);
   endfunction

endpackage

// [rtl/conv_clock_divider_gen.sv]
// Converter clock tick generator: one tick every 2**code system clocks
`timescale 1ns/1ns
module conv_clock_divider_gen
   import adc_seq_pkg::*;
#(
   parameter int unsigned CODE_W = 3
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic [CODE_W-1:0] i_code,
   input  wire logic              i_restart,
   output logic                   o_tick
);

   if (CODE_W < 1 || CODE_W > 3) begin : g_bad_code_w
      $error("conv_clock_divider_gen: CODE_W must be 1 to 3");
   end

   typedef struct packed {
      logic [6:0] cnt;
      logic       tick;
   } div_state_type;

   div_state_type q;
   div_state_type n;
   logic [6:0]    lim;

   always_comb begin
      lim = 7'((8'h01 << i_code) - 8'h01);
      n   = q;
      n.tick = 1'b0;
      if (i_restart) begin
         // Realign so the first converter period is a full one
         n.cnt = DIV_CNT_RESET;
      end else if (q.cnt >= lim) begin
         n.cnt  = DIV_CNT_RESET;
         n.tick = 1'b1;
      end else begin
         n.cnt = q.cnt + 7'h01;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign o_tick = q.tick;

   property p_tick_period;
      @(posedge i_clk) disable iff (!i_rst_n)
      // A code change leaves a stale count for two cycles
      (o_tick && $stable(i_code) && $past(i_code, 2) == i_code && !$past(i_restart))
         |-> ($past(q.cnt) == lim);
   endproperty
   a_tick_period: assert property (p_tick_period)
      else $error("converter tick not at divider limit");

endmodule // conv_clock_divider_gen

// [rtl/adc_conversion_sequencer.sv]
// Converter sequencer: register slave, conversion state machine, result and interrupt
//
// What this block does
// - Sample four clocks, convert twelve, sixteen total
// - Conversion runs on alone after launch
// - Start bit low-high-low launches one conversion
// - Busy high during conversion, low when done
// - External sources route selected pin channel
// - Internal sources disconnect every external channel
// - Software sets divider before enabling and starting
// - Enable powers converter; clear cuts it fully
// - Result twelve bits, full scale FFF
// - Format bit arranges result across bytes
// - Reference source field selects converter reference
// - Converter clock is system clock over 2**code
// - Completion sets flag, interrupts when enabled
`timescale 1ns/1ns
module adc_conversion_sequencer
   import adc_seq_pkg::*;
#(
   parameter int unsigned DIV_CODE_W = 3
) (
   input  wire logic     I_CORE_CLK,
   input  wire logic     I_ARST_N,
   input  wire logic     I_AWVALID,
   output logic          O_AWREADY,
   input  wire logic [31:0] I_AWADDR,
   input  wire logic     I_WVALID,
   output logic          O_WREADY,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   output logic          O_BVALID,
   input  wire logic     I_BREADY,
   output logic [1:0]    O_BRESP,
   input  wire logic     I_ARVALID,
   output logic          O_ARREADY,
   input  wire logic [31:0] I_ARADDR,
   output logic          O_RVALID,
   input  wire logic     I_RREADY,
   output logic [31:0]   O_RDATA,
   output logic [1:0]    O_RRESP,
   input  wire logic     I_CMP_ABOVE,
   output analog_ctl_type O_ANALOG,
   output logic          O_BUSY,
   output logic          O_IRQ
);

   if (DIV_CODE_W != 3) begin : g_bad_div_w
      $error("adc_conversion_sequencer: divider code must be 3 bits");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and converter clock

   logic [1:0]    rst_sync_q;
   logic          rst_n;
   logic          tick;
   logic          launch;
   logic          done;
   logic          rd_clear;
   seq_state_type q;
   seq_state_type n;

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   conv_clock_divider_gen #(
      .CODE_W    (DIV_CODE_W)
   ) u_div (
      .i_clk     (I_CORE_CLK),
      .i_rst_n   (rst_n),
      .i_code    (q.div),
      .i_restart (launch),
      .o_tick    (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Next successive-approximation code: drop the trial bit if below, try the next
   function automatic logic [11:0] sar_step(logic [11:0] s, logic [3:0] c, logic keep);
      logic [11:0] r;
      logic [3:0]  b;
      r = s;
      b = 4'(RES_TOP - c);
      if (!keep) begin
         r[b] = 1'b0;
      end
      if (b != 4'h0) begin
         r[b - 4'h1] = 1'b1;
      end
      return r;
   endfunction

   // Left aligned when fmt is 0, right aligned when 1
   function automatic logic [7:0] res_byte(logic [11:0] r, logic fmt, logic hi);
      logic [15:0] w;
      w = fmt ? {4'h0, r} : {r, 4'h0};
      return hi ? w[15:8] : w[7:0];
   endfunction

   function automatic logic mapped(logic [31:0] a);
      return (a == OFS_CTRL0) || (a == OFS_CTRL1) || (a == OFS_CTRL2) ||
             (a == OFS_RES_HI) || (a == OFS_RES_LO) || (a == OFS_STATUS) ||
             (a == OFS_MASK);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      n        = q;
      launch   = 1'b0;
      done     = 1'b0;
      rd_clear = 1'b0;

      // Comparator pin: third stage only moves the value once stages agree
      n.cmp_s = {q.cmp_s[1:0], I_CMP_ABOVE};
      if (q.cmp_s[1] == q.cmp_s[2]) begin
         n.cmp = q.cmp_s[2];
      end

      // Write channel: address and data taken in either order
      if (I_AWVALID && q.awrdy) begin
         n.have_aw = 1'b1;
         n.awaddr  = I_AWADDR;
      end
      if (I_WVALID && q.wrdy) begin
         n.have_w = 1'b1;
         n.wdata  = I_WDATA;
         n.wstrb  = I_WSTRB;
      end
      if (q.have_aw && q.have_w && !q.bvalid) begin
         n.have_aw = 1'b0;
         n.have_w  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
         if (q.wstrb[0]) begin
            unique case (q.awaddr)
               OFS_CTRL0: begin
                  n.start = q.wdata[START_BIT];
                  n.pwr   = q.wdata[PWR_BIT];
                  n.fmt   = q.wdata[FMT_BIT];
                  n.ch    = q.wdata[CH_LSB +: 4];
               end
               OFS_CTRL1: begin
                  n.src = q.wdata[SRC_LSB +: 4];
                  n.div = q.wdata[DIV_LSB +: 3];
               end
               OFS_CTRL2: n.rsel = q.wdata[REF_LSB +: 2];
               OFS_MASK:  n.mask = q.wdata[DONE_BIT];
               default:   ;
            endcase
         end
      end
      if (q.bvalid && I_BREADY) begin
         n.bvalid = 1'b0;
      end
      n.awrdy = !n.have_aw && !n.bvalid;
      n.wrdy  = !n.have_w && !n.bvalid;

      // Read channel
      if (I_ARVALID && q.arrdy) begin
         n.rvalid = 1'b1;
         n.rresp  = mapped(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
         n.rdata  = 32'h0000_0000;
         unique case (I_ARADDR)
            OFS_CTRL0: begin
               n.rdata[START_BIT]   = q.start;
               n.rdata[PWR_BIT]     = q.pwr;
               n.rdata[BUSY_BIT]    = q.busy;
               n.rdata[FMT_BIT]     = q.fmt;
               n.rdata[CH_LSB +: 4] = q.ch;
            end
            OFS_CTRL1: begin
               n.rdata[SRC_LSB +: 4] = q.src;
               n.rdata[DIV_LSB +: 3] = q.div;
            end
            OFS_CTRL2:  n.rdata[REF_LSB +: 2] = q.rsel;
            OFS_RES_HI: n.rdata[7:0] = res_byte(q.result, q.fmt, 1'b1);
            OFS_RES_LO: n.rdata[7:0] = res_byte(q.result, q.fmt, 1'b0);
            OFS_STATUS: begin
               n.rdata[DONE_BIT] = q.stat;
               rd_clear          = 1'b1;
            end
            OFS_MASK:   n.rdata[DONE_BIT] = q.mask;
            default:    ;
         endcase
      end
      if (q.rvalid && I_RREADY) begin
         n.rvalid = 1'b0;
      end
      n.arrdy = !n.rvalid;

      // Launch on the falling edge of the start bit after it was high
      launch = q.start && !n.start && n.pwr;

      // Sequencer runs from converter ticks alone once launched
      if (!n.pwr) begin
         n.st  = ST_IDLE;
         n.cnt = 4'h0;
      end else if (launch) begin
         n.st  = ST_SAMPLE;
         n.cnt = 4'h0;
      end else if (tick) begin
         unique case (q.st)
            ST_IDLE: ;
            ST_SAMPLE: begin
               if (q.cnt == SAMPLE_CLKS - 4'h1) begin
                  n.st  = ST_CONVERT;
                  n.cnt = 4'h0;
                  n.sar = SAR_FIRST;
               end else begin
                  n.cnt = q.cnt + 4'h1;
               end
            end
            ST_CONVERT: begin
               // Filtered answer of this cycle, so four-clock periods still judge the trial
               n.sar = sar_step(q.sar, q.cnt, n.cmp);
               if (q.cnt == CONV_CLKS - 4'h1) begin
                  // Both bytes come from one store, so they change together
                  n.st     = ST_IDLE;
                  n.result = n.sar;
                  done     = 1'b1;
               end else begin
                  n.cnt = q.cnt + 4'h1;
               end
            end
         endcase
      end

      // Completion beats a same-cycle read clear
      n.stat = done || (q.stat && !rd_clear);
      n.irq  = n.stat && n.mask;
      n.busy = (n.st != ST_IDLE);

      n.ana.power_en    = n.pwr;
      n.ana.sample_en   = (n.st == ST_SAMPLE);
      n.ana.ext_connect = n.pwr && src_is_external(n.src);
      n.ana.ext_sel     = n.ch;
      n.ana.src_sel     = n.src;
      n.ana.ref_sel     = n.rsel;
      n.ana.sar_code    = n.sar;
   end

   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         q <= SEQ_RESET;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign O_AWREADY = q.awrdy;
   assign O_WREADY  = q.wrdy;
   assign O_BVALID  = q.bvalid;
   assign O_BRESP   = q.bresp;
   assign O_ARREADY = q.arrdy;
   assign O_RVALID  = q.rvalid;
   assign O_RDATA   = q.rdata;
   assign O_RRESP   = q.rresp;
   assign O_ANALOG  = q.ana;
   assign O_BUSY    = q.busy;
   assign O_IRQ     = q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!rst_n);

   property p_sample_to_conv;
      (q.st == ST_SAMPLE && tick && q.cnt == 4'h3 && n.pwr && !launch)
         |=> (q.st == ST_CONVERT && q.cnt == 4'h0 && O_ANALOG.sar_code == 12'h800);
   endproperty
   a_sample_to_conv: assert property (p_sample_to_conv)
      else $error("sampling did not end after four converter clocks");

   property p_count_bounds;
      (q.st == ST_SAMPLE |-> q.cnt < 4'h4) and (q.st == ST_CONVERT |-> q.cnt < 4'hC);
   endproperty
   a_count_bounds: assert property (p_count_bounds)
      else $error("phase counter beyond its phase length");

   property p_conv_end;
      done |=> (q.st == ST_IDLE && !O_BUSY && q.result == $past(n.sar) && q.stat);
   endproperty
   a_conv_end: assert property (p_conv_end)
      else $error("completion did not idle, store result and flag");

   property p_launch;
      (launch && q.st == ST_IDLE) |=> (q.st == ST_SAMPLE && q.cnt == 4'h0) ##1 O_BUSY;
   endproperty
   a_launch: assert property (p_launch)
      else $error("start pulse did not launch sampling");

   property p_restart;
      (launch && q.st == ST_CONVERT) |=> (q.st == ST_SAMPLE && q.cnt == 4'h0 && $stable(q.result));
   endproperty
   a_restart: assert property (p_restart)
      else $error("start during conversion did not restart sampling");

   property p_busy;
      O_BUSY == (q.st != ST_IDLE);
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy flag disagrees with sequencer state");

   property p_busy_edges;
      ($rose(O_BUSY) |-> $past(launch)) and ($fell(O_BUSY) |-> ($past(done) || !q.pwr));
   endproperty
   a_busy_edges: assert property (p_busy_edges)
      else $error("busy changed without launch, completion or power-off");

   property p_ext_route;
      (src_is_external(q.src) && q.pwr) |-> (O_ANALOG.ext_connect && O_ANALOG.ext_sel == q.ch);
   endproperty
   a_ext_route: assert property (p_ext_route)
      else $error("external channel not routed");

   property p_int_isolate;
      !src_is_external(q.src) |-> !O_ANALOG.ext_connect;
   endproperty
   a_int_isolate: assert property (p_int_isolate)
      else $error("external channel connected with internal source");

   property p_power_off;
      !q.pwr |-> (!O_ANALOG.power_en && !O_ANALOG.ext_connect && q.st == ST_IDLE);
   endproperty
   a_power_off: assert property (p_power_off)
      else $error("converter not fully off while disabled");

   property p_abort;
      ($past(O_BUSY) && $fell(q.pwr)) |-> (!$rose(q.stat) && !O_BUSY);
   endproperty
   a_abort: assert property (p_abort)
      else $error("abort set the completion flag or left busy");

   property p_result_hold;
      !done |=> $stable(q.result);
   endproperty
   a_result_hold: assert property (p_result_hold)
      else $error("result changed without a completion");

   property p_irq;
      q.stat && q.mask |-> O_IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("unmasked completion flag without interrupt");

endmodule // adc_conversion_sequencer

// [tb/analog_core_model.sv]
// Behavioural analog multiplexer and comparator of the conversion core
`timescale 1ns/1ns
module analog_core_model
   import adc_seq_pkg::*;
(
   input  wire logic           i_clk,
   input  wire analog_ctl_type i_ana,
   input  wire logic [11:0]    i_pin_level,
   input  wire logic [11:0]    i_int_level,
   output logic                o_above
);
   logic        toggle_q = 1'b0;
   logic [11:0] level;

   always_ff @(posedge i_clk) begin
      toggle_q <= ~toggle_q;
   end

   // Each pin sees its own level, so a wrong channel gives a wrong code
   assign level = i_ana.ext_connect ? (i_pin_level ^ {8'h00, i_ana.ext_sel}) : i_int_level;
   // Unpowered core has no settled answer, so it must not look like one
   assign o_above = i_ana.power_en ? (level >= i_ana.sar_code) : toggle_q;

endmodule // analog_core_model

// [tb/tb.sv]
// Self-checking bench of the converter sequencer
`timescale 1ns/1ns
module tb;
   import adc_seq_pkg::*;
   logic           clk = 1'b0;
   logic           arst_n = 1'b0;
   logic           awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic           arvalid = 1'b0, rready = 1'b0;
   logic [31:0]    awaddr = '0, wdata = '0, araddr = '0;
   logic [3:0]     wstrb = '0;
   logic [11:0]    pin_level = '0, int_level = '0;
   logic           awready, wready, bvalid, arready, rvalid, above, busy, irq;
   logic [1:0]     bresp, rresp;
   logic [31:0]    rdata;
   analog_ctl_type ana;
   int             errors = 0;
   int             n_tests = 0;
   int             seed = 32'hf879_0d82;

   always #20 clk = ~clk;

   adc_conversion_sequencer dut (
      .I_CORE_CLK(clk), .I_ARST_N(arst_n),
      .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
      .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(wstrb),
      .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp),
      .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
      .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp),
      .I_CMP_ABOVE(above), .O_ANALOG(ana), .O_BUSY(busy), .O_IRQ(irq)
   );

   analog_core_model core (
      .i_clk(clk), .i_ana(ana), .i_pin_level(pin_level),
      .i_int_level(int_level), .o_above(above)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
         errors++;
      end
   endtask

   // Readies are sampled as they stood at the edge; no cycle count assumed
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      k = 0;
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      bready <= 1'b1;
      while (k < 1000) begin
         @(posedge clk);
         k++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            break;
         end
      end
      if (k >= 1000) begin
         errors++;
         complete_run();
      end
      check(bresp, er);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      int k;
      k = 0;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while (k < 1000) begin
         @(posedge clk);
         k++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            break;
         end
      end
      if (k >= 1000) begin
         errors++;
         complete_run();
      end
      check(rdata, ed);
      check(rresp, er);
   endtask

   task automatic start(input logic [3:0] ch, input logic f);
      wr(OFS_CTRL0, {24'h0, ch, f, 3'b011}, RESP_OKAY);
      wr(OFS_CTRL0, {24'h0, ch, f, 3'b010}, RESP_OKAY);
   endtask

   task automatic measure(input int p, input logic m);
      int cnt;
      cnt = 0;
      while (cnt < 5000) begin
         @(posedge clk);
         if (busy === 1'b1) cnt++;
         else break;
      end
      if (cnt >= 5000) begin
         errors++;
         complete_run();
      end
      // Busy rose at the write edge, one cycle before the response was taken
      check(cnt, 16 * p);
      check(irq, m);
   endtask

   task automatic result(input logic [11:0] r, input logic f);
      rd(OFS_RES_HI, {24'h0, f ? {4'h0, r[11:8]} : r[11:4]}, RESP_OKAY);
      rd(OFS_RES_LO, {24'h0, f ? r[7:0] : {r[3:0], 4'h0}}, RESP_OKAY);
   endtask

   // Ideal successive approximation against a comparator of input >= code
   function automatic logic [11:0] sar(input logic [11:0] lvl);
      logic [11:0] c;
      c = 12'h000;
      for (int b = 11; b >= 0; b--) begin
         if (lvl >= (c | (12'h001 << b))) c = c | (12'h001 << b);
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [11:0] r;
      logic [3:0]  ch;
      logic        m;
      logic        f;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(OFS_CTRL0, 32'h0, RESP_OKAY);
      rd(OFS_CTRL1, 32'h0, RESP_OKAY);
      rd(OFS_STATUS, 32'h0, RESP_OKAY);
      rd(32'h0000_001C, 32'h0, RESP_SLVERR);
      wr(32'h0000_0020, 32'h0000_00FF, RESP_SLVERR);
      $display("test reset and map done");
      for (int s = 0; s < 16; s++) begin
         ch = $random(seed);
         wr(OFS_CTRL1, s, RESP_OKAY);
         wr(OFS_CTRL2, s % 4, RESP_OKAY);
         wr(OFS_CTRL0, {24'h0, ch, 4'h2}, RESP_OKAY);
         repeat (2) @(posedge clk);
         check(ana.ext_connect, (s == 0) || (s == 4) || (s >= 12));
         check({ana.ext_sel, ana.src_sel}, {ch, 4'(s)});
         check(ana.ref_sel, s % 4);
      end
      wr(OFS_CTRL0, {24'h0, ch, 4'h0}, RESP_OKAY);
      repeat (2) @(posedge clk);
      check({ana.power_en, ana.ext_connect}, 2'b00);
      wr(OFS_CTRL0, 32'h0000_0001, RESP_OKAY);
      wr(OFS_CTRL0, 32'h0000_0000, RESP_OKAY);
      repeat (3) @(posedge clk);
      check(busy, 1'b0);
      $display("test routing and power done");
      wr(OFS_CTRL0, 32'h0000_0002, RESP_OKAY);
      repeat (50) @(posedge clk);
      for (int c = 0; c < 8; c++) begin
         r = (c == 2) ? 12'hFFF : (c == 3) ? 12'h000 : 12'($random(seed));
         ch = $random(seed);
         m = $random(seed);
         f = $random(seed);
         pin_level <= r ^ {8'h00, ch};
         wr(OFS_MASK, m, RESP_OKAY);
         wr(OFS_CTRL1, c << DIV_LSB, RESP_OKAY);
         start(ch, f);
         measure(2 ** c, m);
         if (c >= 2) result(sar(r), f);
         rd(OFS_STATUS, 32'h1, RESP_OKAY);
         rd(OFS_STATUS, 32'h0, RESP_OKAY);
         @(posedge clk);
         check(irq, 1'b0);
      end
      $display("test conversions done");
      pin_level <= $random(seed);
      wr(OFS_CTRL1, 32'h0000_0020, RESP_OKAY);
      start(ch, f);
      repeat (20) @(posedge clk);
      rd(OFS_CTRL0, {24'h0, ch, f, 3'b110}, RESP_OKAY);
      wr(OFS_CTRL0, {24'h0, ch, f, 3'b000}, RESP_OKAY);
      repeat (2) @(posedge clk);
      check(busy, 1'b0);
      rd(OFS_STATUS, 32'h0, RESP_OKAY);
      result(sar(r), f);
      $display("test abort done");
      wr(OFS_CTRL0, {24'h0, ch, f, 3'b010}, RESP_OKAY);
      repeat (50) @(posedge clk);
      start(ch, f);
      repeat (30) @(posedge clk);
      r = $random(seed);
      pin_level <= r ^ {8'h00, ch};
      start(ch, f);
      measure(4, m);
      result(sar(r), f);
      $display("test restart done");
      complete_run();
   end

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      complete_run();
   end

endmodule // tb
